// >>> hdl/dwc_pkg.sv
package dwc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int PROG_W = 20;
    localparam int SETTLE_W = 8;

    // ----------------------------------------------------------------
    // Field sizes and values
    // ----------------------------------------------------------------
    localparam int VAL_W = 6;
    localparam int TAPS = 64;
    localparam logic [VAL_W-1:0] TAP_MAX = 6'h3f;
    localparam logic [VAL_W-1:0] TAP_MIN = 6'h00;
    localparam logic [VAL_W-1:0] STEP_ONE = 6'h01;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] FIRST_BIT = 4'h1;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_INSTR = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;
    localparam logic [1:0] SEL_FIRST = 2'h0;
    localparam logic [1:0] POT_BOTH = 2'h3;
    localparam logic [1:0] POT_NONE = 2'h0;
    localparam logic [1:0] DATA_PAD = 2'h0;

    typedef enum logic [3:0] {
        OP_RD_WIPER = 4'h9,
        OP_WR_WIPER = 4'ha,
        OP_RD_SET = 4'hb,
        OP_WR_SET = 4'hc,
        OP_SET_TO_WIPER = 4'hd,
        OP_WIPER_TO_SET = 4'he,
        OP_GLB_SET_TO_WIPER = 4'h1,
        OP_GLB_WIPER_TO_SET = 4'h8,
        OP_STEP = 4'h2
    } dwc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100,
        ST_STEP = 3'b101,
        ST_IGNORE = 3'b110
    } dwc_state_t;

    typedef struct packed {
        logic [3:0] opcode;
        logic zero;
        logic pot_select_bit;
        logic setting_select_hi;
        logic setting_select_lo;
    } dwc_instr_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } dwc_bus_ev_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic instr_ok(input dwc_instr_t i);
        logic sel_zero;
        sel_zero = !i.setting_select_hi && !i.setting_select_lo;
        instr_ok = 1'b0;
        if (!i.zero) begin
            case (i.opcode)
                OP_RD_WIPER, OP_WR_WIPER, OP_STEP: instr_ok = sel_zero;
                OP_RD_SET, OP_WR_SET, OP_SET_TO_WIPER, OP_WIPER_TO_SET: instr_ok = 1'b1;
                OP_GLB_SET_TO_WIPER, OP_GLB_WIPER_TO_SET: instr_ok = !i.pot_select_bit;
                default: instr_ok = 1'b0;
            endcase
        end
    endfunction : instr_ok

    function automatic logic [1:0] pot_mask(input dwc_instr_t i);
        if (i.opcode == OP_GLB_SET_TO_WIPER || i.opcode == OP_GLB_WIPER_TO_SET) begin
            pot_mask = POT_BOTH;
        end else begin
            pot_mask = i.pot_select_bit ? 2'h2 : 2'h1;
        end
    endfunction : pot_mask

    function automatic logic [TAPS-1:0] tap_decode(input logic [VAL_W-1:0] v);
        tap_decode = {{(TAPS-1){1'b0}}, 1'b1} << v;
    endfunction : tap_decode

    function automatic logic [VAL_W-1:0] step_wiper(input logic [VAL_W-1:0] v,
                                                    input logic up);
        if (up) begin
            step_wiper = (v == TAP_MAX) ? v : v + STEP_ONE;
        end else begin
            step_wiper = (v == TAP_MIN) ? v : v - STEP_ONE;
        end
    endfunction : step_wiper

endpackage : dwc_pkg

// >>> hdl/dwc_bus_sync.sv
`timescale 1ns/10ps
module dwc_bus_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic [3:0] straps,
    output dwc_pkg::dwc_bus_ev_t ev,
    output logic [3:0] strap_q
);

    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [3:0] strap_m;

    // ----------------------------------------------------------------
    // Two-stage synchronisers, then one delay stage for edge finding
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            strap_m <= 4'h0;
            strap_q <= 4'h0;
        end else begin
            strap_m <= straps;
            strap_q <= strap_m;
        end
    end

    // Data moving while the clock is high marks a start or a stop.
    assign ev = '{start: scl_s & scl_d & sda_d & ~sda_s,
                  stop: scl_s & scl_d & ~sda_d & sda_s,
                  rise: scl_s & ~scl_d,
                  fall: ~scl_s & scl_d,
                  sda: sda_s};

endmodule : dwc_bus_sync

// >>> hdl/dwc_store.sv
`timescale 1ns/10ps
module dwc_store (
    input wire logic clock,
    input wire logic [1:0] rd_sel,
    input wire logic [1:0] wr_sel,
    input wire logic [1:0] wr_en,
    input wire logic [1:0][dwc_pkg::VAL_W-1:0] wr_data,
    output logic [1:0][dwc_pkg::VAL_W-1:0] rd_data
);

    // Stands in for the nonvolatile array, so it has no reset; a blank array reads as zero.
    logic [dwc_pkg::VAL_W-1:0] stored_setting_reg [0:1][0:3] = '{default: '0};

    always_ff @(posedge clock) begin
        for (int p = 0; p < 2; p++) begin
            if (wr_en[p]) begin
                stored_setting_reg[p][wr_sel] <= wr_data[p];
            end
            rd_data[p] <= stored_setting_reg[p][rd_sel];
        end
    end

endmodule : dwc_store

// >>> hdl/dwc_decoder.sv
`timescale 1ns/10ps
module dwc_decoder #(
    parameter logic [3:0] DEV_TYPE_ID = 4'ha, // Arbitrary value.
    parameter int PROG_CYCLES = dwc_pkg::PROG_CYCLES,
    parameter int WIPER_SETTLE_DELAY = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [3:0] address_strap_pins,
    output logic [dwc_pkg::TAPS-1:0] tap_sel_0,
    output logic [dwc_pkg::TAPS-1:0] tap_sel_1,
    output logic prog_busy
);

    dwc_pkg::dwc_bus_ev_t ev;
    dwc_pkg::dwc_state_t state;
    dwc_pkg::dwc_instr_t instr;
    dwc_pkg::dwc_instr_t cur;
    logic [3:0] strap;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] rd_byte;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic drive_low;
    logic mack_ok;
    logic ack_ok;
    logic byte_done;
    logic instr_done;
    logic [1:0][dwc_pkg::VAL_W-1:0] wiper_position_reg;
    logic [1:0][dwc_pkg::VAL_W-1:0] rd_data;
    logic [1:0][dwc_pkg::VAL_W-1:0] wr_data;
    logic [1:0] rd_sel;
    logic step_arm;
    logic step_up;
    logic step_fire;
    logic wr_wiper;
    logic copy_start;
    logic [1:0] xfer_mask;
    logic [dwc_pkg::SETTLE_W-1:0] xfer_cnt;
    logic xfer_fire;
    logic prog_pend;
    logic prog_src;
    logic [1:0] prog_we;
    logic [1:0] prog_sel;
    logic [dwc_pkg::VAL_W-1:0] prog_data;
    logic [dwc_pkg::PROG_W-1:0] prog_cnt;
    logic [1:0] mem_we;

    dwc_bus_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .scl(scl),
        .sda_in(sda_in),
        .straps(address_strap_pins),
        .ev(ev),
        .strap_q(strap)
    );

    dwc_store u_store (
        .clock(clock),
        .rd_sel(rd_sel),
        .wr_sel(prog_sel),
        .wr_en(mem_we),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // ----------------------------------------------------------------
    // Byte decode
    // ----------------------------------------------------------------
    assign cur = dwc_pkg::dwc_instr_t'(shreg);
    assign byte_done = (state == dwc_pkg::ST_RX) && ev.fall && (cnt == dwc_pkg::BYTE_BITS);
    assign instr_done = byte_done && (idx == dwc_pkg::IDX_INSTR) && dwc_pkg::instr_ok(cur);

    always_comb begin
        case (idx)
            dwc_pkg::IDX_ADDR: ack_ok = (shreg[7:4] == DEV_TYPE_ID)
                && (shreg[3:0] == strap) && !prog_busy;
            dwc_pkg::IDX_INSTR: ack_ok = dwc_pkg::instr_ok(cur);
            default: ack_ok = 1'b1;
        endcase
    end

    always_comb begin
        if (instr.opcode == dwc_pkg::OP_RD_WIPER) begin
            rd_byte = {dwc_pkg::DATA_PAD, wiper_position_reg[instr.pot_select_bit]};
        end else begin
            rd_byte = {dwc_pkg::DATA_PAD, rd_data[instr.pot_select_bit]};
        end
    end

    // ----------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= dwc_pkg::ST_IDLE;
            cnt <= 4'h0;
            idx <= dwc_pkg::IDX_ADDR;
            drive_low <= 1'b0;
            shreg <= 8'h00;
            tx <= 8'h00;
            instr <= '0;
            mack_ok <= 1'b0;
        end else if (ev.stop) begin
            state <= dwc_pkg::ST_IDLE;
            drive_low <= 1'b0;
        end else if (ev.start) begin
            state <= dwc_pkg::ST_RX;
            cnt <= 4'h0;
            idx <= dwc_pkg::IDX_ADDR;
            drive_low <= 1'b0;
        end else begin
            case (state)
                dwc_pkg::ST_RX: begin
                    if (ev.rise) begin
                        shreg <= {shreg[6:0], ev.sda};
                        cnt <= cnt + dwc_pkg::FIRST_BIT;
                    end else if (byte_done) begin
                        if (idx == dwc_pkg::IDX_INSTR) begin
                            instr <= cur;
                        end
                        if (ack_ok) begin
                            drive_low <= 1'b1;
                            state <= dwc_pkg::ST_ACK;
                        end else begin
                            state <= dwc_pkg::ST_IGNORE;
                        end
                    end
                end
                dwc_pkg::ST_ACK: begin
                    if (ev.fall) begin
                        drive_low <= 1'b0;
                        cnt <= 4'h0;
                        idx <= idx + 2'h1;
                        state <= dwc_pkg::ST_IGNORE;
                        if (idx == dwc_pkg::IDX_ADDR) begin
                            state <= dwc_pkg::ST_RX;
                        end else if (idx == dwc_pkg::IDX_INSTR) begin
                            case (instr.opcode)
                                dwc_pkg::OP_RD_WIPER, dwc_pkg::OP_RD_SET: begin
                                    drive_low <= ~rd_byte[7];
                                    tx <= {rd_byte[6:0], 1'b0};
                                    cnt <= dwc_pkg::FIRST_BIT;
                                    state <= dwc_pkg::ST_TX;
                                end
                                dwc_pkg::OP_WR_WIPER, dwc_pkg::OP_WR_SET: state <= dwc_pkg::ST_RX;
                                dwc_pkg::OP_STEP: state <= dwc_pkg::ST_STEP;
                                default: state <= dwc_pkg::ST_IGNORE;
                            endcase
                        end
                    end
                end
                dwc_pkg::ST_TX: begin
                    if (ev.fall) begin
                        if (cnt == dwc_pkg::BYTE_BITS) begin
                            drive_low <= 1'b0;
                            state <= dwc_pkg::ST_MACK;
                        end else begin
                            drive_low <= ~tx[7];
                            tx <= {tx[6:0], 1'b0};
                            cnt <= cnt + dwc_pkg::FIRST_BIT;
                        end
                    end
                end
                dwc_pkg::ST_MACK: begin
                    if (ev.rise) begin
                        mack_ok <= ~ev.sda;
                    end else if (ev.fall) begin
                        if (mack_ok) begin
                            drive_low <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b0};
                            cnt <= dwc_pkg::FIRST_BIT;
                            state <= dwc_pkg::ST_TX;
                        end else begin
                            state <= dwc_pkg::ST_IGNORE;
                        end
                    end
                end
                default: state <= state;
            endcase
        end
    end

    // Open-drain data: only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe = drive_low;

    // ----------------------------------------------------------------
    // Stepping
    // ----------------------------------------------------------------
    // The level is taken at the rising clock and applied at the falling
    // one, so a stop during the high phase adds no stray step.
    always_ff @(posedge clock) begin
        if (!rstn || state != dwc_pkg::ST_STEP) begin
            step_arm <= 1'b0;
            step_up <= 1'b0;
        end else if (ev.rise) begin
            step_arm <= 1'b1;
            step_up <= ev.sda;
        end else if (ev.fall) begin
            step_arm <= 1'b0;
        end
    end

    assign step_fire = (state == dwc_pkg::ST_STEP) && ev.fall && step_arm;
    assign wr_wiper = byte_done && (idx == dwc_pkg::IDX_DATA)
        && (instr.opcode == dwc_pkg::OP_WR_WIPER);
    assign copy_start = instr_done && (cur.opcode == dwc_pkg::OP_SET_TO_WIPER
        || cur.opcode == dwc_pkg::OP_GLB_SET_TO_WIPER);

    // ----------------------------------------------------------------
    // Setting-to-wiper copies, power-up recall included
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_sel <= dwc_pkg::SEL_FIRST;
        end else if (instr_done) begin
            rd_sel <= {cur.setting_select_hi, cur.setting_select_lo};
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            xfer_mask <= dwc_pkg::POT_BOTH;
            xfer_cnt <= dwc_pkg::SETTLE_W'(WIPER_SETTLE_DELAY - 1);
        end else if (copy_start) begin
            xfer_mask <= dwc_pkg::pot_mask(cur);
            xfer_cnt <= dwc_pkg::SETTLE_W'(WIPER_SETTLE_DELAY - 1);
        end else if (xfer_cnt != '0) begin
            xfer_cnt <= xfer_cnt - 1'b1;
        end else begin
            xfer_mask <= dwc_pkg::POT_NONE;
        end
    end

    assign xfer_fire = (xfer_mask != dwc_pkg::POT_NONE) && (xfer_cnt == '0);

    // ----------------------------------------------------------------
    // Wiper position registers and tap decode
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wiper_position_reg <= '0;
        end else if (wr_wiper) begin
            wiper_position_reg[instr.pot_select_bit] <= shreg[dwc_pkg::VAL_W-1:0];
        end else if (step_fire) begin
            wiper_position_reg[instr.pot_select_bit] <= dwc_pkg::step_wiper(
                wiper_position_reg[instr.pot_select_bit], step_up);
        end else if (xfer_fire) begin
            for (int p = 0; p < 2; p++) begin
                if (xfer_mask[p]) begin
                    wiper_position_reg[p] <= rd_data[p];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tap_sel_0 <= dwc_pkg::tap_decode(dwc_pkg::TAP_MIN);
            tap_sel_1 <= dwc_pkg::tap_decode(dwc_pkg::TAP_MIN);
        end else begin
            tap_sel_0 <= dwc_pkg::tap_decode(wiper_position_reg[0]);
            tap_sel_1 <= dwc_pkg::tap_decode(wiper_position_reg[1]);
        end
    end

    // ----------------------------------------------------------------
    // Nonvolatile program operations
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            prog_pend <= 1'b0;
            prog_src <= 1'b0;
            prog_we <= dwc_pkg::POT_NONE;
            prog_sel <= dwc_pkg::SEL_FIRST;
            prog_data <= '0;
        end else if (ev.stop) begin
            prog_pend <= 1'b0;
        end else if (byte_done && idx == dwc_pkg::IDX_DATA
                     && instr.opcode == dwc_pkg::OP_WR_SET) begin
            prog_pend <= 1'b1;
            prog_src <= 1'b0;
            prog_we <= dwc_pkg::pot_mask(instr);
            prog_sel <= {instr.setting_select_hi, instr.setting_select_lo};
            prog_data <= shreg[dwc_pkg::VAL_W-1:0];
        end else if (instr_done && (cur.opcode == dwc_pkg::OP_WIPER_TO_SET
                     || cur.opcode == dwc_pkg::OP_GLB_WIPER_TO_SET)) begin
            prog_pend <= 1'b1;
            prog_src <= 1'b1;
            prog_we <= dwc_pkg::pot_mask(cur);
            prog_sel <= {cur.setting_select_hi, cur.setting_select_lo};
        end
    end

    assign mem_we = (ev.stop && prog_pend) ? prog_we : dwc_pkg::POT_NONE;
    assign wr_data[0] = prog_src ? wiper_position_reg[0] : prog_data;
    assign wr_data[1] = prog_src ? wiper_position_reg[1] : prog_data;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            prog_busy <= 1'b0;
            prog_cnt <= '0;
        end else if (mem_we != dwc_pkg::POT_NONE) begin
            prog_busy <= 1'b1;
            prog_cnt <= dwc_pkg::PROG_W'(PROG_CYCLES - 1);
        end else if (prog_cnt != '0) begin
            prog_cnt <= prog_cnt - 1'b1;
        end else begin
            prog_busy <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_busy_no_ack: assert property (
        byte_done && idx == dwc_pkg::IDX_ADDR && prog_busy
        |=> state == dwc_pkg::ST_IGNORE && !sda_oe ##1 !sda_oe)
        else $error("address acknowledged while programming");
    chk_addr_mismatch: assert property (
        byte_done && idx == dwc_pkg::IDX_ADDR && shreg[3:0] != strap
        |=> state == dwc_pkg::ST_IGNORE)
        else $error("foreign strap address accepted");
    chk_type_mismatch: assert property (
        byte_done && idx == dwc_pkg::IDX_ADDR && shreg[7:4] != DEV_TYPE_ID
        |=> !sda_oe)
        else $error("foreign type identifier accepted");
    chk_ack_hold: assert property (
        state == dwc_pkg::ST_ACK |-> sda_oe)
        else $error("acknowledge not driven");
    chk_wiper_write: assert property (
        wr_wiper |=> wiper_position_reg[$past(instr.pot_select_bit)]
        == $past(shreg[dwc_pkg::VAL_W-1:0]))
        else $error("wiper write lost");
    chk_step_top: assert property (
        step_fire && step_up && wiper_position_reg[instr.pot_select_bit] == dwc_pkg::TAP_MAX
        |=> $stable(wiper_position_reg))
        else $error("step past top tap");
    chk_prog_at_stop: assert property (
        $rose(prog_busy) |-> $past(ev.stop) && $past(prog_pend))
        else $error("program started without stop");
    chk_prog_len: assert property (
        $rose(prog_busy) |-> prog_cnt == dwc_pkg::PROG_W'(PROG_CYCLES - 1))
        else $error("wrong program length");
    chk_nack_quiet: assert property (
        state == dwc_pkg::ST_MACK && ev.fall && !mack_ok && !ev.stop && !ev.start
        |=> state == dwc_pkg::ST_IGNORE && !sda_oe)
        else $error("sending continued after no-acknowledge");
    chk_tap_onehot: assert property (
        $onehot(tap_sel_0) && $onehot(tap_sel_1))
        else $error("tap select not one-hot");

    cov_read_done: cover property (state == dwc_pkg::ST_MACK && ev.fall);
    cov_step: cover property (step_fire);
    cov_program: cover property ($rose(prog_busy));
    cov_copy: cover property (xfer_fire && xfer_mask == dwc_pkg::POT_BOTH);

endmodule : dwc_decoder

// >>> dv/dwc_ctrl_model.sv
`timescale 1ns/10ps
module dwc_ctrl_model (
    input wire logic clock,
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output logic sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge clock);
    endtask : gap
    // Data moves only while the bus clock is low, so no false frame edge is seen.
    task automatic xbit(input logic b, output logic s);
        sda_m = b;
        gap(4);
        scl = 1'b1;
        gap(2);
        s = sda_m & (sda_oe ? sda_out : 1'b1);
        gap(2);
        scl = 1'b0;
    endtask : xbit
    task automatic start();
        gap(4);
        sda_m = 1'b0;
        gap(4);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        gap(4);
        scl = 1'b1;
        gap(4);
        sda_m = 1'b1;
        gap(8);
    endtask : stop
    task automatic xbyte(input logic [7:0] b, input logic ak, output logic [7:0] r,
                         output logic a);
        for (int i = 7; i >= 0; i--) xbit(b[i], r[i]);
        xbit(ak, a);
    endtask : xbyte
endmodule : dwc_ctrl_model

// >>> dv/test_dual_wiper_command_decoder.sv
`timescale 1ns/10ps
module test_dual_wiper_command_decoder;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] st = 4'h0;
    logic [63:0] t0, t1;
    logic scl, sda_m, sda_out, sda_oe, prog_busy, a;
    logic [7:0] r;
    logic [5:0] s [2];
    logic [5:0] w;
    int seed = 95;
    int fails = 0;
    int n_tests = 0;
    always #5 clock = ~clock;
    dwc_decoder #(.DEV_TYPE_ID(4'ha), .PROG_CYCLES(200)) dwc_decoder_i (.clock(clock),
        .rstn(rstn), .scl(scl), .sda_in(sda_m & (sda_oe ? sda_out : 1'b1)),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pins(st), .tap_sel_0(t0),
        .tap_sel_1(t1), .prog_busy(prog_busy));
    dwc_ctrl_model dwc_ctrl_model_i (.clock(clock), .sda_oe(sda_oe), .sda_out(sda_out),
        .scl(scl), .sda_m(sda_m));
    function automatic logic [63:0] tap(input logic [5:0] x);
        tap = 64'h1 << x;
    endfunction : tap
    function automatic logic [7:0] op(input logic [3:0] o, input logic p, input logic [1:0] q);
        op = {o, 1'b0, p, q};
    endfunction : op
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic adr(input logic [7:0] b);
        dwc_ctrl_model_i.start();
        dwc_ctrl_model_i.xbyte(b, 1'b1, r, a);
    endtask : adr
    task automatic cmd(input logic [7:0] ins, input int m, input logic [7:0] d);
        logic q;
        adr({4'ha, st});
        chk("addr ack", 1'b0, a);
        dwc_ctrl_model_i.xbyte(ins, 1'b1, r, a);
        chk("instr ack", 1'b0, a);
        if (m == 1) dwc_ctrl_model_i.xbyte(d, 1'b1, r, a);
        if (m == 1) chk("data ack", 1'b0, a);
        if (m == 4) dwc_ctrl_model_i.xbyte(8'hff, 1'b0, r, a);
        if (m == 2 || m == 4) dwc_ctrl_model_i.xbyte(8'hff, 1'b1, r, a);
        for (int i = 7; i >= 0 && m == 3; i--) dwc_ctrl_model_i.xbit(d[i], q);
        dwc_ctrl_model_i.stop();
    endtask : cmd
    task automatic poll();
        chk("busy", 1'b1, prog_busy);
        for (int k = 0; k < 40; k++) begin
            adr({4'ha, st});
            dwc_ctrl_model_i.stop();
            if (k == 0) chk("busy nack", 1'b1, a);
            if (a === 1'b0) break;
        end
        chk("poll ack", 1'b0, a);
    endtask : poll
    initial begin
        #900000;
        fails++;
        give_verdict();
    end
    initial begin
        st = 4'($random(seed));
        for (int p = 0; p < 2; p++) s[p] = 6'($random(seed));
        w = 6'($random(seed));
        repeat (4) @(negedge clock);
        chk("reset tap", 64'h1, t0);
        rstn = 1'b1;
        repeat (20) @(negedge clock);
        for (int k = 0; k < 2; k++) begin
            adr(k == 0 ? {4'h6, st} : {4'ha, ~st});
            dwc_ctrl_model_i.stop();
            chk("addr nack", 1'b1, a);
        end
        adr({4'ha, st});
        dwc_ctrl_model_i.xbyte(op(4'h9, 1'b0, 2'h1), 1'b1, r, a);
        dwc_ctrl_model_i.stop();
        chk("bad instr", 1'b1, a);
        for (int p = 0; p < 2; p++) begin
            cmd(op(4'hc, 1'(p), 2'h0), 1, {2'h3, s[p]});
            poll();
        end
        cmd(op(4'hc, 1'b0, 2'h2), 1, {2'h0, w});
        poll();
        rstn = 1'b0;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (20) @(negedge clock);
        chk("recall 0", tap(s[0]), t0);
        chk("recall 1", tap(s[1]), t1);
        cmd(op(4'hb, 1'b1, 2'h0), 2, 8'h0);
        chk("rd set", {2'h0, s[1]}, r);
        cmd(op(4'ha, 1'b1, 2'h0), 1, 8'hfe);
        chk("wr wiper", tap(6'h3e), t1);
        cmd(op(4'h9, 1'b1, 2'h0), 2, 8'h0);
        chk("rd wiper", 8'h3e, r);
        cmd(op(4'h9, 1'b1, 2'h0), 4, 8'h0);
        chk("rd again", 8'h3e, r);
        cmd(op(4'h2, 1'b1, 2'h0), 3, 8'he0);
        chk("step hi", tap(6'h3a), t1);
        cmd(op(4'ha, 1'b0, 2'h0), 1, 8'h01);
        cmd(op(4'h2, 1'b0, 2'h0), 3, 8'h01);
        chk("step lo", tap(6'h01), t0);
        cmd(op(4'hd, 1'b0, 2'h2), 0, 8'h0);
        chk("copy in", tap(w), t0);
        cmd(op(4'he, 1'b1, 2'h3), 0, 8'h0);
        poll();
        cmd(op(4'hb, 1'b1, 2'h3), 2, 8'h0);
        chk("copy out", 8'h3a, r);
        cmd(op(4'h1, 1'b0, 2'h0), 0, 8'h0);
        chk("glb in 0", tap(s[0]), t0);
        chk("glb in 1", tap(s[1]), t1);
        cmd(op(4'h8, 1'b0, 2'h1), 0, 8'h0);
        poll();
        cmd(op(4'hb, 1'b1, 2'h1), 2, 8'h0);
        chk("glb out", {2'h0, s[1]}, r);
        give_verdict();
    end
endmodule : test_dual_wiper_command_decoder
